// >>> shared/dasm_pkg.sv
/*
 * Constants and carrier types for the dual converter status and mode
 * control block. Assumes an 8-bit special function register bus and two
 * external converter datapaths that report completion events.
 */
package dasm_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] DASM_MODE_ADDR = 8'hd1;
    localparam logic [7:0] DASM_STAT_ADDR = 8'hd8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DASM_MODE_RST = 8'h00;
    localparam logic [7:0] DASM_STAT_RST = 8'h00;

    // ==========================================================
    // Status register fields
    localparam int DASM_PRIMARY_READY_FLAG_BIT = 7;
    localparam int DASM_AUXILIARY_READY_FLAG_BIT = 6;
    localparam int DASM_CAL_BIT = 5;
    localparam int DASM_NOREF_BIT = 4;
    localparam int DASM_PRIMARY_ERROR_FLAG_BIT = 3;
    localparam int DASM_AUXILIARY_ERROR_FLAG_BIT = 2;

    // ==========================================================
    // Mode register fields
    localparam int DASM_EN0_BIT = 5;
    localparam int DASM_EN1_BIT = 4;
    localparam int DASM_MD_LSB = 0;
    localparam int DASM_MD_MSB = 2;

    localparam int DASM_NCONV = 2;
    localparam logic [15:0] DASM_ALL_ONES = 16'hffff;
    localparam logic [15:0] DASM_ALL_ZEROS = 16'h0000;

    // ==========================================================
    // Mode field encodings
    typedef enum logic [2:0] {
        DASM_MD_PDOWN = 3'h0,
        DASM_MD_IDLE = 3'h1,
        DASM_MD_SINGLE = 3'h2,
        DASM_MD_CONT = 3'h3,
        DASM_MD_INT_ZS = 3'h4,
        DASM_MD_INT_FS = 3'h5,
        DASM_MD_SYS_ZS = 3'h6,
        DASM_MD_SYS_FS = 3'h7
    } dasm_mode_t;

    // ==========================================================
    // Converter datapath carriers
    typedef struct packed {
        logic conv_done;
        logic cal_done;
        logic cal_fault;
        logic [15:0] result;
    } dasm_conv_in_t;

    typedef struct packed {
        logic enable;
        logic reset;
        logic result_we;
        logic coef_we;
        logic [15:0] result;
    } dasm_conv_out_t;

endpackage

// >>> verilog/dasm_ctrl.sv
/*
 * Status and mode control for a primary and an auxiliary converter.
 * Assumes the core drives an 8-bit register bus synchronous to clock_i,
 * and that each converter datapath pulses its done inputs for one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Primary ready sets on conversion or calibration done
// - Primary ready clears by software or mode start
// - Set primary ready blocks further primary writes
// - Auxiliary ready behaves alike for auxiliary converter
// - Calibration-done flag sets when calibration finishes
// - Calibration-done clears only by mode start write
// - Missing reference flags while a converter active
// - Missing external reference forces results all ones
// - Missing reference clears on valid reference
// - Primary error sets on saturated primary result
// - Primary error sets on failed calibration update
// - Primary error clears on mode start write
// - Auxiliary error behaves alike for auxiliary converter
// - Primary enable bit powers primary converter
// - Auxiliary enable bit powers auxiliary converter
// - Three-bit mode field selects operating mode
// - Mode register at D1H, resets to 00H
// - Mode field decodes eight operating modes
// - Single conversion done returns mode to power-down
// - Any mode write resets both converters
// - Calibration write clears ready, finish returns power-down
module dasm_ctrl
    import dasm_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic ref_valid_i,
    input wire logic ext_ref_i,
    input wire dasm_conv_in_t [DASM_NCONV-1:0] conv_i,
    output dasm_conv_out_t [DASM_NCONV-1:0] conv_o,
    output logic [2:0] mode_o
);

    // ==========================================================
    // Register state
    dasm_mode_t mode_q;
    dasm_mode_t mode_d;
    logic [DASM_NCONV-1:0] en_q;
    logic [DASM_NCONV-1:0] rdy_q;
    logic [DASM_NCONV-1:0] err_q;
    logic cal_q;
    logic noref_q;
    logic [7:0] rdata_q;
    logic [2:0] mode_out_q;
    logic [DASM_NCONV-1:0] res_we_q;
    logic [DASM_NCONV-1:0] coef_we_q;
    logic [DASM_NCONV-1:0] pwr_q;
    logic [DASM_NCONV-1:0] crst_q;
    logic [15:0] res_q [DASM_NCONV];

    // ==========================================================
    // Bus decode
    logic mode_wr;
    logic stat_wr;
    logic start_wr;
    dasm_mode_t wr_mode;

    assign mode_wr = sfr_wr_i && (sfr_addr_i == DASM_MODE_ADDR);
    assign stat_wr = sfr_wr_i && (sfr_addr_i == DASM_STAT_ADDR);
    assign wr_mode = dasm_mode_t'(sfr_wdata_i[DASM_MD_MSB:DASM_MD_LSB]);

    // Modes that begin a conversion or a calibration
    always_comb begin
        unique case (wr_mode)
            DASM_MD_PDOWN: start_wr = 1'b0;
            DASM_MD_IDLE: start_wr = 1'b0;
            DASM_MD_SINGLE: start_wr = mode_wr;
            DASM_MD_CONT: start_wr = mode_wr;
            DASM_MD_INT_ZS: start_wr = mode_wr;
            DASM_MD_INT_FS: start_wr = mode_wr;
            DASM_MD_SYS_ZS: start_wr = mode_wr;
            DASM_MD_SYS_FS: start_wr = mode_wr;
        endcase
    end

    // ==========================================================
    // Current mode classes
    logic conv_mode;
    logic cal_mode;
    logic single_mode;

    always_comb begin
        conv_mode = 1'b0;
        cal_mode = 1'b0;
        single_mode = 1'b0;
        unique case (mode_q)
            DASM_MD_PDOWN: conv_mode = 1'b0;
            DASM_MD_IDLE: conv_mode = 1'b0;
            DASM_MD_SINGLE: begin
                conv_mode = 1'b1;
                single_mode = 1'b1;
            end
            DASM_MD_CONT: conv_mode = 1'b1;
            DASM_MD_INT_ZS: cal_mode = 1'b1;
            DASM_MD_INT_FS: cal_mode = 1'b1;
            DASM_MD_SYS_ZS: cal_mode = 1'b1;
            DASM_MD_SYS_FS: cal_mode = 1'b1;
        endcase
    end

    logic any_active;
    logic clamp;

    assign any_active = (|en_q) && (conv_mode || cal_mode);
    assign clamp = noref_q && ext_ref_i;

    // ==========================================================
    // Per-converter event handling
    logic [DASM_NCONV-1:0] acc_conv;
    logic [DASM_NCONV-1:0] acc_cal;
    logic [DASM_NCONV-1:0] sat;
    logic [DASM_NCONV-1:0] sw_clr;
    logic [DASM_NCONV-1:0] rdy_bit_wr;
    logic [15:0] res_val [DASM_NCONV];

    assign rdy_bit_wr[0] = sfr_wdata_i[DASM_PRIMARY_READY_FLAG_BIT];
    assign rdy_bit_wr[1] = sfr_wdata_i[DASM_AUXILIARY_READY_FLAG_BIT];

    generate
        for (genvar i = 0; i < DASM_NCONV; i++) begin : g_conv
            // Events are taken only while the ready flag is clear
            assign acc_conv[i] = conv_i[i].conv_done && !rdy_q[i] && en_q[i]
                && conv_mode;
            assign acc_cal[i] = conv_i[i].cal_done && !rdy_q[i] && en_q[i]
                && cal_mode;

            // Results forced high without an external reference
            assign res_val[i] = clamp ? DASM_ALL_ONES : conv_i[i].result;
            assign sat[i] = (res_val[i] == DASM_ALL_ONES)
                || (res_val[i] == DASM_ALL_ZEROS);

            // Direct clear: writing zero to the ready bit
            assign sw_clr[i] = stat_wr && !rdy_bit_wr[i];

            // Ready flag, set wins over clear
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    rdy_q[i] <= 1'b0;
                end else if (acc_conv[i] || acc_cal[i]) begin
                    rdy_q[i] <= 1'b1;
                end else if (sw_clr[i] || start_wr) begin
                    rdy_q[i] <= 1'b0;
                end
            end

            // Error flag, set wins over clear
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    err_q[i] <= 1'b0;
                end else if ((acc_conv[i] && sat[i])
                    || (acc_cal[i] && conv_i[i].cal_fault)) begin
                    err_q[i] <= 1'b1;
                end else if (start_wr) begin
                    err_q[i] <= 1'b0;
                end
            end

            // Result write strobe, one cycle per accepted conversion
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    res_we_q[i] <= 1'b0;
                end else begin
                    res_we_q[i] <= acc_conv[i];
                end
            end

            // Coefficient strobe withheld on a failed calibration
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    coef_we_q[i] <= 1'b0;
                end else begin
                    coef_we_q[i] <= acc_cal[i] && !conv_i[i].cal_fault;
                end
            end

            // Result word held between conversions
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    res_q[i] <= DASM_ALL_ZEROS;
                end else if (acc_conv[i]) begin
                    res_q[i] <= res_val[i];
                end
            end

            // Converter power follows enable and mode
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pwr_q[i] <= 1'b0;
                end else begin
                    pwr_q[i] <= en_q[i] && (mode_q != DASM_MD_PDOWN);
                end
            end

            // Both converters restart on every mode write
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    crst_q[i] <= 1'b0;
                end else begin
                    crst_q[i] <= mode_wr;
                end
            end

            // Outgoing carrier built from one register per field, 16 flops for the result
            assign conv_o[i] = '{
                enable: pwr_q[i],
                reset: crst_q[i],
                result_we: res_we_q[i],
                coef_we: coef_we_q[i],
                result: res_q[i]
            };
        end
    endgenerate

    // ==========================================================
    // Mode register
    logic finish;

    // Single conversion or calibration completion ends the command
    assign finish = (single_mode && (|acc_conv)) || (|acc_cal);

    always_comb begin
        mode_d = mode_q;
        if (mode_wr) begin
            mode_d = wr_mode;
        end else if (finish) begin
            mode_d = DASM_MD_PDOWN;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= dasm_mode_t'(DASM_MODE_RST[DASM_MD_MSB:DASM_MD_LSB]);
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q <= {DASM_MODE_RST[DASM_EN1_BIT], DASM_MODE_RST[DASM_EN0_BIT]};
        end else if (mode_wr) begin
            en_q[0] <= sfr_wdata_i[DASM_EN0_BIT];
            en_q[1] <= sfr_wdata_i[DASM_EN1_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_out_q <= DASM_MODE_RST[DASM_MD_MSB:DASM_MD_LSB];
        end else begin
            mode_out_q <= mode_d;
        end
    end

    // ==========================================================
    // Calibration-done flag
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cal_q <= DASM_STAT_RST[DASM_CAL_BIT];
        end else if (|acc_cal) begin
            cal_q <= 1'b1;
        end else if (start_wr) begin
            cal_q <= 1'b0;
        end
    end

    // ==========================================================
    // Reference detect
    // Valid reference wins; the flag holds while converters sit idle
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            noref_q <= DASM_STAT_RST[DASM_NOREF_BIT];
        end else if (ref_valid_i) begin
            noref_q <= 1'b0;
        end else if (any_active) begin
            noref_q <= 1'b1;
        end
    end

    // ==========================================================
    // Read path
    logic [7:0] stat_val;
    logic [7:0] mode_val;
    logic [7:0] rd_mux;

    // Unlisted bits stay zero
    always_comb begin
        stat_val = 8'h00;
        stat_val[DASM_PRIMARY_READY_FLAG_BIT] = rdy_q[0];
        stat_val[DASM_AUXILIARY_READY_FLAG_BIT] = rdy_q[1];
        stat_val[DASM_CAL_BIT] = cal_q;
        stat_val[DASM_NOREF_BIT] = noref_q;
        stat_val[DASM_PRIMARY_ERROR_FLAG_BIT] = err_q[0];
        stat_val[DASM_AUXILIARY_ERROR_FLAG_BIT] = err_q[1];
    end

    always_comb begin
        mode_val = 8'h00;
        mode_val[DASM_EN0_BIT] = en_q[0];
        mode_val[DASM_EN1_BIT] = en_q[1];
        mode_val[DASM_MD_MSB:DASM_MD_LSB] = mode_q;
    end

    always_comb begin
        if (sfr_addr_i == DASM_MODE_ADDR) begin
            rd_mux = mode_val;
        end else if (sfr_addr_i == DASM_STAT_ADDR) begin
            rd_mux = stat_val;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Read data lags the address by one edge, no read strobe needed
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end

    // ==========================================================
    // Outputs
    assign sfr_rdata_o = rdata_q;
    assign mode_o = mode_out_q;

endmodule // dasm_ctrl

`default_nettype wire

// >>> verification/dasm_ctrl_props.sv
/* Checker for dasm_ctrl port behaviour.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module dasm_ctrl_props
    import dasm_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic ref_valid_i,
    input wire logic ext_ref_i,
    input wire dasm_conv_in_t [DASM_NCONV-1:0] conv_i,
    input wire dasm_conv_out_t [DASM_NCONV-1:0] conv_o,
    input wire logic [2:0] mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    wire logic mwr = sfr_wr_i && sfr_addr_i == DASM_MODE_ADDR;
    wire logic cal_ok0 = conv_i[0].cal_done && !conv_i[0].cal_fault;
    wire logic pass0 = conv_o[0].result_we && ref_valid_i;
    // ==========
    // Single conversion steps
    sequence s_single_take;
        conv_i[0].conv_done && mode_o == DASM_MD_SINGLE && !mwr;
    endsequence
    sequence s_result_out;
        conv_o[0].result_we;
    endsequence
    a_mode_wr_reset: assert property (mwr |=> conv_o[0].reset && conv_o[1].reset)
        else $error("converter reset missing after mode write");
    a_reset_no_wr: assert property (!mwr |=> !conv_o[0].reset && !conv_o[1].reset)
        else $error("converter reset without mode write");
    a_mode_field_load: assert property (mwr |=> mode_o == $past(sfr_wdata_i[2:0]))
        else $error("mode field not loaded");
    a_power_down: assert property ((mode_o == DASM_MD_PDOWN) [*2] |->
        !conv_o[0].enable && !conv_o[1].enable)
        else $error("converter enabled in power-down");
    a_result_pulse: assert property (conv_o[0].result_we && !$past(mwr) |=>
        !conv_o[0].result_we)
        else $error("result written while ready set");
    a_single_to_pd: assert property (s_single_take ##1 s_result_out |->
        mode_o == DASM_MD_PDOWN)
        else $error("single conversion left mode active");
    a_coef_cause: assert property (conv_o[0].coef_we |-> $past(cal_ok0))
        else $error("coefficient write without good calibration");
    a_result_pass: assert property ($past(ref_valid_i, 2) && pass0 |->
        conv_o[0].result == $past(conv_i[0].result))
        else $error("result altered with valid reference");
    a_mode_reserved: assert property (sfr_addr_i == DASM_MODE_ADDR |=>
        (sfr_rdata_o & 8'hc8) == 8'h00)
        else $error("mode reserved bits not zero");
    a_unmapped_zero: assert property (sfr_addr_i != DASM_MODE_ADDR &&
        sfr_addr_i != DASM_STAT_ADDR |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // dasm_ctrl_props
`default_nettype wire

// >>> verification/dasm_conv_model.sv
/* Converter datapath stand-in raising completion events.
   Assumes the bench calls fire between clock edges. */
`timescale 1ns/1ps
`default_nettype none
module dasm_conv_model
    import dasm_pkg::*;
(
    input wire logic clock_i,
    output dasm_conv_in_t [DASM_NCONV-1:0] conv_o
);
    // ==========
    // One-cycle completion pulse
    initial conv_o = '0;
    task automatic fire(input int i, input logic cal, input logic flt, input logic [15:0] r);
        @(posedge clock_i) #1;
        conv_o[i] = '{~cal, cal, flt, r};
        @(posedge clock_i) #1;
        conv_o[i] = '{1'b0, 1'b0, ~flt, ~r}; // Stale data not held
    endtask
endmodule // dasm_conv_model
`default_nettype wire

// >>> verification/dasm_ctrl_tb.sv
/* Self-checking bench for dasm_ctrl.
   Assumes the checker and converter stand-in are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dasm_ctrl_tb
    import dasm_pkg::*;
;
    logic clock_i = 0;
    logic arst_n_i = 0;
    logic sfr_wr_i = 0;
    logic ref_valid_i = 1;
    logic ext_ref_i = 1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    wire logic [7:0] sfr_rdata_o;
    wire logic [2:0] mode_o;
    dasm_conv_in_t [DASM_NCONV-1:0] conv_i;
    dasm_conv_out_t [DASM_NCONV-1:0] conv_o;
    int mismatches = 0;
    int checks = 0;
    initial forever #20 clock_i = ~clock_i;
    dasm_ctrl u_dasm_ctrl (.clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .ref_valid_i(ref_valid_i), .ext_ref_i(ext_ref_i), .conv_i(conv_i),
        .conv_o(conv_o), .mode_o(mode_o));
    dasm_conv_model u_dasm_conv_model (.clock_i(clock_i), .conv_o(conv_i));
    // ==========
    // Bus and compare helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i) #1;
        sfr_wr_i = 1;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        @(posedge clock_i) #1;
        sfr_wr_i = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i) #1;
        sfr_addr_i = a;
        @(posedge clock_i) #1;
        chk("register read", 16'(e), 16'(sfr_rdata_o));
    endtask
    task automatic fire(input int i, input logic cal, input logic flt, input logic [15:0] r);
        u_dasm_conv_model.fire(i, cal, flt, r);
    endtask
    // ==========
    // Scenarios
    task automatic t_fields;
        rd(DASM_MODE_ADDR, 8'h00);
        rd(DASM_STAT_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        wr(DASM_MODE_ADDR, 8'hff);
        rd(DASM_MODE_ADDR, 8'h37);
        chk("mode_o", 16'h7, 16'(mode_o));
        wr(DASM_STAT_ADDR, 8'hff);
        rd(DASM_STAT_ADDR, 8'h00);
        wr(DASM_MODE_ADDR, 8'h00);
        $display("test fields done");
    endtask
    task automatic t_single;
        wr(DASM_MODE_ADDR, 8'h22);
        fire(0, 0, 0, 16'h1234);
        chk("result_we0", 16'h1, 16'(conv_o[0].result_we));
        chk("result0", 16'h1234, conv_o[0].result);
        rd(DASM_STAT_ADDR, 8'h80);
        rd(DASM_MODE_ADDR, 8'h20);
        fire(0, 0, 0, 16'h4321);
        chk("result_we0", 16'h0, 16'(conv_o[0].result_we));
        $display("test single done");
    endtask
    task automatic t_cont;
        wr(DASM_MODE_ADDR, 8'h33);
        rd(DASM_STAT_ADDR, 8'h00);
        chk("enable0", 16'h1, 16'(conv_o[0].enable));
        chk("enable1", 16'h1, 16'(conv_o[1].enable));
        fire(1, 0, 0, 16'h00ff);
        chk("result1", 16'h00ff, conv_o[1].result);
        fire(1, 0, 0, 16'h0000);
        chk("result_we1", 16'h0, 16'(conv_o[1].result_we));
        wr(DASM_STAT_ADDR, 8'h00);
        fire(1, 0, 0, 16'h0000);
        rd(DASM_STAT_ADDR, 8'h44);
        $display("test continuous done");
    endtask
    task automatic t_cal;
        wr(DASM_MODE_ADDR, 8'h24);
        rd(DASM_STAT_ADDR, 8'h00);
        chk("enable1", 16'h0, 16'(conv_o[1].enable));
        fire(0, 1, 1, 16'h0000);
        chk("coef_we0", 16'h0, 16'(conv_o[0].coef_we));
        rd(DASM_STAT_ADDR, 8'ha8);
        rd(DASM_MODE_ADDR, 8'h20);
        wr(DASM_STAT_ADDR, 8'h00);
        rd(DASM_STAT_ADDR, 8'h28);
        wr(DASM_MODE_ADDR, 8'h25);
        fire(0, 1, 0, 16'h0000);
        chk("coef_we0", 16'h1, 16'(conv_o[0].coef_we));
        rd(DASM_STAT_ADDR, 8'ha0);
        $display("test calibration done");
    endtask
    task automatic t_noref;
        ref_valid_i = 0;
        rd(DASM_STAT_ADDR, 8'ha0);
        wr(DASM_MODE_ADDR, 8'h23);
        rd(DASM_STAT_ADDR, 8'h10);
        fire(0, 0, 0, 16'h1234);
        chk("result0", DASM_ALL_ONES, conv_o[0].result);
        rd(DASM_STAT_ADDR, 8'h98);
        ext_ref_i = 0;
        wr(DASM_STAT_ADDR, 8'h00);
        fire(0, 0, 0, 16'h1234);
        chk("result0", 16'h1234, conv_o[0].result);
        ext_ref_i = 1;
        ref_valid_i = 1;
        rd(DASM_STAT_ADDR, 8'h88);
        $display("test reference done");
    endtask
    task automatic t_idle_reset;
        wr(DASM_MODE_ADDR, 8'h11);
        fire(1, 0, 0, 16'h0001);
        chk("result_we1", 16'h0, 16'(conv_o[1].result_we));
        chk("enable1", 16'h1, 16'(conv_o[1].enable));
        wr(DASM_MODE_ADDR, 8'h16);
        fire(1, 1, 0, 16'h0000);
        chk("coef_we1", 16'h1, 16'(conv_o[1].coef_we));
        rd(DASM_MODE_ADDR, 8'h10);
        rd(DASM_STAT_ADDR, 8'h60);
        @(posedge clock_i) #1;
        arst_n_i = 0;
        @(posedge clock_i) #1;
        arst_n_i = 1;
        rd(DASM_MODE_ADDR, 8'h00);
        rd(DASM_STAT_ADDR, 8'h00);
        chk("mode_o", 16'h0, 16'(mode_o));
        $display("test idle and reset done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(5000 * 40);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        #1 arst_n_i = 1;
        t_fields();
        t_single();
        t_cont();
        t_cal();
        t_noref();
        t_idle_reset();
        complete_run();
    end
endmodule // dasm_ctrl_tb
bind dasm_ctrl dasm_ctrl_props u_dasm_ctrl_props (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .ref_valid_i(ref_valid_i), .ext_ref_i(ext_ref_i),
    .conv_i(conv_i), .conv_o(conv_o), .mode_o(mode_o));
`default_nettype wire
